// ---- hpp_pkg.sv ----
// Shared constants for the parallel host port device and host ends.
package hpp_pkg;
  // DSP-side register indices.
  localparam logic [2:0] R_CTRL = 3'h0;
  localparam logic [2:0] R_PINS = 3'h1;
  localparam logic [2:0] R_STAT = 3'h2;
  localparam logic [2:0] R_BASE = 3'h3;
  localparam logic [2:0] R_RXW = 3'h4;
  localparam logic [2:0] R_TXW = 3'h5;
  localparam logic [2:0] R_GPD = 3'h6;
  localparam logic [2:0] R_GPDIR = 3'h7;
  // Host-side byte offsets.
  localparam logic [2:0] H_HCTL = 3'h0;
  localparam logic [2:0] H_CMD = 3'h1;
  localparam logic [2:0] H_ISR = 3'h2;
  localparam logic [2:0] H_HIGH = 3'h5;
  localparam logic [2:0] H_MID = 3'h6;
  localparam logic [2:0] H_LOW = 3'h7;
  localparam int H_CMD_BIT = 7;
  // Control register fields.
  localparam int C_RXIE = 0;
  localparam int C_TXIE = 1;
  localparam int C_CMDIE = 2;
  localparam int C_FLAG2 = 3;
  localparam int C_FLAG3 = 4;
  localparam int C_DM_LO = 5;
  // Pin-control fields.
  localparam int P_GEN = 0;
  localparam int P_A8 = 1;
  localparam int P_A9 = 2;
  localparam int P_CS = 3;
  localparam int P_REN = 4;
  localparam int P_AEN = 5;
  localparam int P_EN = 6;
  localparam int P_ROD = 8;
  localparam int P_DSP = 9;
  localparam int P_ASP = 10;
  localparam int P_MUX = 11;
  localparam int P_DDS = 12;
  localparam int P_CSP = 13;
  localparam int P_RP = 14;
  localparam int P_AP = 15;
  // Host-side control fields.
  localparam int I_RXREQ = 0;
  localparam int I_TXREQ = 1;
  localparam int I_SPLIT = 2;
  localparam int I_FLAG0 = 3;
  localparam int I_FLAG1 = 4;
  localparam int I_LE = 5;
  localparam int I_HM_LO = 5;
  // Reset values.
  localparam logic [7:0] RST_BASE = 8'h80;
  localparam logic [15:0] RST_GP = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Vector offsets from the vector base.
  localparam logic [7:0] VEC_RX = 8'h60;
  localparam logic [7:0] VEC_TX = 8'h62;
  localparam logic [7:0] VEC_CMD = 8'h64;
  // Mode codes and DMA width codes.
  localparam logic [2:0] DM_OFF = 3'h0;
  localparam logic [2:0] DM_HOST = 3'h4;
  localparam logic [1:0] W_NONE = 2'h0;
  // Host cycle: strobe cycles before the read sample.
  localparam logic [1:0] HOLD_CYC = 2'h2;
  // Lane of a host byte offset: 0 low, 1 mid, 2 high, 3 none.
  function automatic logic [1:0] lane_of(logic [2:0] off, logic le);
    logic [1:0] l;
    l = 2'h3;
    if (off == H_MID) begin
      l = 2'h1;
    end else if (off == H_HIGH) begin
      l = le ? 2'h0 : 2'h2;
    end else if (off == H_LOW) begin
      l = le ? 2'h2 : 2'h0;
    end
    return l;
  endfunction
endpackage

// ---- hpp_link_if.sv ----
// Host bus pins between the host end and the device end.
`timescale 1ns/1ns
interface hpp_link_if;
  logic [10:0] h_addr;
  logic [7:0] h_wdata;
  logic h_cs;
  logic h_as;
  logic h_ds;
  logic h_rd;
  logic h_rw;
  logic [7:0] d_rdata;
  logic d_data_oe_b;
  logic req_out;
  logic req_oe_b;
  logic ack_out;
  logic ack_oe_b;
  logic req_wire;
  logic ack_wire;
  // Undriven request pins float high through the board pull-up.
  assign req_wire = req_oe_b ? 1'b1 : req_out;
  assign ack_wire = ack_oe_b ? 1'b1 : ack_out;
  modport dev (input h_addr, h_wdata, h_cs, h_as, h_ds, h_rd, h_rw,
    output d_rdata, d_data_oe_b, req_out, req_oe_b, ack_out, ack_oe_b);
  modport host (output h_addr, h_wdata, h_cs, h_as, h_ds, h_rd, h_rw,
    input d_rdata, d_data_oe_b, req_wire, ack_wire);
endinterface

// ---- hpp_irq_pick.sv ----
// Fixed-priority choice among the port's three interrupt sources.
`timescale 1ns/1ns
module hpp_irq_pick
  import hpp_pkg::*;
(
  input wire logic cmd,
  input wire logic rx,
  input wire logic tx,
  output logic valid,
  output logic [7:0] vec
);
  always_comb begin
    valid = cmd | rx | tx;
    vec = VEC_TX;
    if (cmd) begin
      vec = VEC_CMD;
    end else if (rx) begin
      vec = VEC_RX;
    end
  end
endmodule

// ---- hpp_dev.sv ----
// Device end: DSP-side registers, host bus slave and port pin control.
`timescale 1ns/1ns
module hpp_dev
  import hpp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  output logic irq_req,
  output logic [7:0] irq_vec,
  input wire logic irq_ack,
  output logic [1:0] dma_width,
  output logic dma_to_host,
  input wire logic [15:0] gp_in,
  output logic [15:0] gp_out,
  output logic [15:0] gp_oe_b,
  hpp_link_if.dev link
);
  logic [7:0] ctrl_q, base_q, hctl_q;
  logic [15:0] pins_q, gpd_q, gpdir_q, gp_s1_q, gp_s2_q;
  logic [23:0] rxw_q, txw_q;
  logic full_q, empty_q, cmd_q, stb_q;
  logic [10:0] alat_q;
  logic [2:0] dm;
  logic en, mux, a8, a9, cs_en, req_en, split, ack_en, od, rpol;
  logic sel, hit, wr_act, rd_act, stb, fire, ds_act;
  logic [10:0] addr;
  logic [1:0] lane;
  logic host_wr, host_rd, rx_done, tx_done, dsp_rd_rx, dsp_wr_tx;
  logic req_as, ack_as, pick_v;
  logic [7:0] pick_vec, isr;
  logic [15:0] claim;

  assign dm = ctrl_q[C_DM_LO +: 3];
  assign en = pins_q[P_EN];
  assign mux = en & pins_q[P_MUX];
  assign od = en & pins_q[P_ROD];
  assign rpol = en & pins_q[P_RP];
  assign a8 = en & (pins_q[P_A8] | ~mux);
  assign a9 = en & (pins_q[P_A9] | ~mux);
  assign cs_en = en & pins_q[P_CS];
  assign split = hctl_q[I_SPLIT] & (dm == DM_OFF);
  assign req_en = en & pins_q[P_REN];
  assign ack_en = req_en & pins_q[P_AEN] & ~split;

  assign sel = cs_en ? (link.h_cs == pins_q[P_CSP]) : 1'b1;
  assign addr = mux ? alat_q : link.h_addr;
  assign hit = sel & (~mux | (addr[10:3] == base_q));
  assign ds_act = link.h_ds == pins_q[P_DSP];
  assign wr_act = pins_q[P_DDS] ? ds_act : ds_act & ~link.h_rw;
  assign rd_act = pins_q[P_DDS] ? (link.h_rd == pins_q[P_DSP])
                                : ds_act & link.h_rw;
  assign stb = en & hit & (wr_act | rd_act);
  assign fire = stb & ~stb_q;
  assign host_wr = fire & wr_act;
  assign host_rd = fire & rd_act;
  // byte order only in mode 000
  assign lane = lane_of(addr[2:0], hctl_q[I_LE] & (dm == DM_OFF));
  assign rx_done = host_wr & (lane == 2'h0);
  assign tx_done = host_rd & (lane == 2'h0);
  assign dsp_rd_rx = reg_rd & (reg_addr == R_RXW);
  assign dsp_wr_tx = reg_wr & (reg_addr == R_TXW);
  assign isr = {ack_as | req_as, 2'b00, ctrl_q[C_FLAG3], ctrl_q[C_FLAG2],
                ~full_q, ~full_q, ~empty_q};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alat_q <= '0;
      stb_q <= 1'b0;
    end else begin
      if (mux && link.h_as == pins_q[P_ASP]) begin
        alat_q <= link.h_addr;
      end
      stb_q <= stb;
    end
  end

  // DSP-side control registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= RST_BYTE;
      pins_q <= RST_GP;
      base_q <= RST_BASE;
      gpd_q <= RST_GP;
      gpdir_q <= RST_GP;
      txw_q <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        R_CTRL: ctrl_q <= reg_wdata[7:0];
        R_PINS: pins_q <= reg_wdata[15:0];
        R_BASE: base_q <= reg_wdata[7:0];
        R_TXW: txw_q <= reg_wdata;
        R_GPD: gpd_q <= reg_wdata[15:0];
        R_GPDIR: gpdir_q <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Host-side control register and receive word.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hctl_q <= RST_BYTE;
      rxw_q <= '0;
    end else if (host_wr) begin
      if (addr[2:0] == H_HCTL) begin
        hctl_q <= link.h_wdata;
      end
      if (lane != 2'h3) begin
        rxw_q[lane*8 +: 8] <= link.h_wdata;
      end
    end
  end

  // Hardware set wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      full_q <= 1'b0;
      empty_q <= 1'b1;
      cmd_q <= 1'b0;
    end else begin
      if (rx_done) begin
        full_q <= 1'b1;
      end else if (dsp_rd_rx) begin
        full_q <= 1'b0;
      end
      if (tx_done) begin
        empty_q <= 1'b1;
      end else if (dsp_wr_tx) begin
        empty_q <= 1'b0;
      end
      if (host_wr && addr[2:0] == H_CMD && link.h_wdata[H_CMD_BIT]) begin
        cmd_q <= 1'b1;
      end else if (irq_ack && irq_vec == VEC_CMD) begin
        cmd_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        R_CTRL: reg_rdata <= {16'h0000, ctrl_q};
        R_PINS: reg_rdata <= {8'h00, pins_q};
        // status with DMA and host flags
        R_STAT: reg_rdata <= {16'h0000, dm != DM_OFF, 2'b00,
                              hctl_q[I_FLAG1], hctl_q[I_FLAG0], cmd_q,
                              empty_q, full_q};
        R_BASE: reg_rdata <= {16'h0000, base_q};
        R_RXW: reg_rdata <= rxw_q;
        R_GPD: reg_rdata <= {8'h00, (gpdir_q & gpd_q) | (~gpdir_q & gp_s2_q)};
        R_GPDIR: reg_rdata <= {8'h00, gpdir_q};
        default: reg_rdata <= '0;
      endcase
    end
  end

  // Host read data stands while the read strobe stays active.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.d_rdata <= RST_BYTE;
      link.d_data_oe_b <= 1'b1;
    end else begin
      link.d_data_oe_b <= ~(stb & rd_act);
      if (host_rd) begin
        if (lane != 2'h3) begin
          link.d_rdata <= txw_q[lane*8 +: 8];
        end else if (addr[2:0] == H_ISR) begin
          link.d_rdata <= isr;
        end else if (addr[2:0] == H_HCTL) begin
          link.d_rdata <= hctl_q;
        end else begin
          link.d_rdata <= RST_BYTE;
        end
      end
    end
  end

  assign ack_as = split & hctl_q[I_RXREQ] & ~empty_q;
  assign req_as = split ? hctl_q[I_TXREQ] & ~full_q
                        : (hctl_q[I_RXREQ] & ~empty_q) |
                          (hctl_q[I_TXREQ] & ~full_q);

  // Open drain only pulls low; the high level comes from the pull-up.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.req_out <= 1'b0;
      link.req_oe_b <= 1'b1;
      link.ack_out <= 1'b0;
      link.ack_oe_b <= 1'b1;
    end else begin
      link.req_out <= od ? 1'b0 : (req_as == rpol);
      link.req_oe_b <= ~req_en | (od & (req_as == rpol));
      link.ack_out <= od ? 1'b0 : (ack_as == rpol);
      link.ack_oe_b <= ~(req_en & split) | (od & (ack_as == rpol));
    end
  end

  hpp_irq_pick u_pick (
    .cmd(cmd_q & ctrl_q[C_CMDIE]),
    .rx(full_q & ctrl_q[C_RXIE]),
    .tx(empty_q & ctrl_q[C_TXIE]),
    .valid(pick_v),
    .vec(pick_vec)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_req <= 1'b0;
      irq_vec <= VEC_TX;
      dma_width <= W_NONE;
      dma_to_host <= 1'b0;
    end else begin
      irq_req <= pick_v;
      irq_vec <= pick_vec;
      if (dm == DM_HOST) begin
        dma_width <= hctl_q[I_HM_LO +: 2];
        dma_to_host <= hctl_q[I_RXREQ];
      end else begin
        dma_width <= dm[1:0];
        dma_to_host <= dm[2];
      end
    end
  end

  // Pins taken by the host role are never general purpose.
  assign claim = {{3{en}}, req_en & (split | ack_en), req_en, cs_en,
                  a9, a8, {8{en}}};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gp_s1_q <= RST_GP;
      gp_s2_q <= RST_GP;
      gp_out <= RST_GP;
      gp_oe_b <= 16'hFFFF;
    end else begin
      gp_s1_q <= gp_in;
      gp_s2_q <= gp_s1_q;
      gp_out <= gpd_q;
      gp_oe_b <= ~({16{pins_q[P_GEN]}} & ~claim & gpdir_q);
    end
  end
endmodule

// ---- hpp_host.sv ----
// Host end: turns single-cycle user commands into host bus cycles.
`timescale 1ns/1ns
module hpp_host
  import hpp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] cfg_pins,
  input wire logic [10:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic busy,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic req_seen,
  output logic ack_seen,
  hpp_link_if.host link
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ADDR = 4'b0010,
    S_STRB = 4'b0100,
    S_HOLD = 4'b1000
  } hpp_state_e;

  hpp_state_e st_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic dsp, dual, on;

  assign dsp = cfg_pins[P_DSP];
  assign dual = cfg_pins[P_DDS];
  assign on = st_q == S_STRB || st_q == S_HOLD;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      rd_q <= 1'b0;
      cnt_q <= '0;
      busy <= 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: if (cmd_wr || cmd_rd) begin
          st_q <= S_ADDR;
          rd_q <= cmd_rd;
          busy <= 1'b1;
        end
        S_ADDR: st_q <= S_STRB;
        S_STRB: begin
          st_q <= S_HOLD;
          cnt_q <= HOLD_CYC - 2'h1;
        end
        S_HOLD: begin
          cnt_q <= cnt_q - 2'h1;
          if (cnt_q == 2'h1) begin
            st_q <= S_IDLE;
            busy <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link.h_addr <= '0;
      link.h_wdata <= RST_BYTE;
      link.h_cs <= 1'b1;
      link.h_as <= 1'b1;
      link.h_ds <= 1'b1;
      link.h_rd <= 1'b1;
      link.h_rw <= 1'b1;
    end else begin
      if (st_q == S_IDLE && (cmd_wr || cmd_rd)) begin
        link.h_addr <= cmd_addr;
        link.h_wdata <= cmd_wdata;
        link.h_rw <= cmd_rd;
      end
      link.h_cs <= cfg_pins[P_CSP] ^
                   ~(st_q != S_IDLE || cmd_wr || cmd_rd);
      link.h_as <= cfg_pins[P_ASP] ^
                   ~(st_q == S_IDLE && (cmd_wr || cmd_rd) && cfg_pins[P_MUX]);
      link.h_ds <= dsp ^ ~(((st_q == S_ADDR) || (on && cnt_q != 2'h1)
                   || st_q == S_STRB) & (~dual | ~rd_q));
      link.h_rd <= dsp ^ ~(((st_q == S_ADDR) || (on && cnt_q != 2'h1)
                   || st_q == S_STRB) & dual & rd_q);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= RST_BYTE;
      rvalid <= 1'b0;
      req_seen <= 1'b0;
      ack_seen <= 1'b0;
    end else begin
      rvalid <= st_q == S_HOLD && cnt_q == 2'h1 && rd_q;
      if (st_q == S_HOLD && cnt_q == 2'h1 && rd_q) begin
        rdata <= link.d_rdata;
      end
      // request pins seen at their polarity
      req_seen <= link.req_wire == cfg_pins[P_RP];
      ack_seen <= link.ack_wire == cfg_pins[P_RP];
    end
  end
endmodule

// ---- hpp_link_chk.sv ----
// Checker for the host bus between the device and host ends.
`timescale 1ns/1ns
module hpp_link_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [10:0] h_addr,
  input wire logic [7:0] h_wdata,
  input wire logic h_cs,
  input wire logic h_ds,
  input wire logic h_rd,
  input wire logic [7:0] d_rdata,
  input wire logic d_data_oe_b
);
  logic ds_q;
  logic rd_q;
  logic [1:0] chg_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Polarity may change, so any strobe edge counts as a cause.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ds_q <= 1'h1;
      rd_q <= 1'h1;
      chg_q <= 2'h0;
    end else begin
      ds_q <= h_ds;
      rd_q <= h_rd;
      chg_q <= {chg_q[0], (h_ds != ds_q) || (h_rd != rd_q)};
    end
  end
  property p_oe_cause;
    $fell(d_data_oe_b) |-> |chg_q;
  endproperty
  a_oe_cause: assert property (p_oe_cause)
    else $error("read drive without strobe edge");
  property p_oe_release;
    $fell(d_data_oe_b) |-> ##[1:4] $rose(d_data_oe_b);
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("read drive not released");
  property p_oe_gap;
    $rose(d_data_oe_b) |=> d_data_oe_b ##1 d_data_oe_b;
  endproperty
  a_oe_gap: assert property (p_oe_gap)
    else $error("read drive restarted at once");
  property p_rdata_hold;
    !d_data_oe_b && !$past(d_data_oe_b) |-> $stable(d_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved while driven");
  property p_addr_hold;
    $fell(d_data_oe_b) |-> $stable(h_addr) && $stable(h_cs)
      ##1 $stable(h_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved during read");
  property p_ds_width;
    $changed(h_ds) |=> $stable(h_ds);
  endproperty
  a_ds_width: assert property (p_ds_width)
    else $error("data strobe too short");
  property p_rd_width;
    $changed(h_rd) |=> $stable(h_rd);
  endproperty
  a_rd_width: assert property (p_rd_width)
    else $error("read strobe too short");
  property p_wdata_hold;
    $changed(h_ds) |=> $stable(h_wdata);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold)
    else $error("write data moved at strobe");
  c_read: cover property ($fell(d_data_oe_b));
  c_dual: cover property ($changed(h_rd));
  c_cs: cover property ($changed(h_cs));
endmodule

// ---- hpp_bench.sv ----
// Self-checking bench joining the host and device ends of the port.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module hpp_bench
  import hpp_pkg::*;
();
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [2:0] reg_addr = 3'h0;
  logic [23:0] reg_wdata = 24'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic irq_ack = 1'h0;
  logic [15:0] gp_in = 16'h0;
  logic [15:0] cfg_pins = 16'h0;
  logic [10:0] cmd_addr = 11'h0;
  logic [7:0] cmd_wdata = 8'h0;
  logic cmd_wr = 1'h0;
  logic cmd_rd = 1'h0;
  logic [23:0] reg_rdata;
  logic irq_req;
  logic [7:0] irq_vec;
  logic [1:0] dma_width;
  logic dma_to_host;
  logic [15:0] gp_out;
  logic [15:0] gp_oe_b;
  logic busy;
  logic [7:0] rdata;
  logic rvalid;
  logic req_seen;
  logic ack_seen;
  int n_mismatch = 0;
  int n_compared = 0;
  hpp_link_if link ();
  hpp_dev i_hpp_dev (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .irq_req, .irq_vec, .irq_ack, .dma_width, .dma_to_host,
    .gp_in, .gp_out, .gp_oe_b, .link(link));
  hpp_host i_hpp_host (.clk, .rst_b, .cfg_pins, .cmd_addr, .cmd_wdata,
    .cmd_wr, .cmd_rd, .busy, .rdata, .rvalid, .req_seen, .ack_seen,
    .link(link));
  hpp_link_chk i_hpp_link_chk (.clk, .rst_b, .h_addr(link.h_addr),
    .h_wdata(link.h_wdata), .h_cs(link.h_cs), .h_ds(link.h_ds),
    .h_rd(link.h_rd), .d_rdata(link.d_rdata),
    .d_data_oe_b(link.d_data_oe_b));
  always #5 clk = ~clk;
  task automatic dw(input logic [2:0] a, input logic [23:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic dr(input logic [2:0] a, output logic [23:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic hc(input logic [2:0] o, input logic [7:0] d,
    input logic w, output logic [7:0] q);
    @(posedge clk);
    cmd_addr <= {RST_BASE, o};
    cmd_wdata <= d;
    cmd_wr <= w;
    cmd_rd <= !w;
    @(posedge clk);
    cmd_wr <= 1'h0;
    cmd_rd <= 1'h0;
    q = 8'h0;
    for (int k = 0; k < 12; k++) begin
      @(posedge clk);
      if (rvalid === 1'h1) q = rdata;
      if (busy === 1'h0) break;
    end
    `CHK("host done", 1'h0, busy)
  endtask
  // The low lane goes last in either byte order, since it completes a word.
  task automatic hw24(input logic [23:0] w, input logic le);
    logic [7:0] q;
    hc(le ? H_LOW : H_HIGH, w[23:16], 1'h1, q);
    hc(H_MID, w[15:8], 1'h1, q);
    hc(le ? H_HIGH : H_LOW, w[7:0], 1'h1, q);
  endtask
  task automatic hr24(input logic le, output logic [23:0] w);
    hc(le ? H_LOW : H_HIGH, 8'h00, 1'h0, w[23:16]);
    hc(H_MID, 8'h00, 1'h0, w[15:8]);
    hc(le ? H_HIGH : H_LOW, 8'h00, 1'h0, w[7:0]);
  endtask
  // The port is off while the host end changes its idle levels.
  task automatic pins(input logic [15:0] p);
    dw(R_PINS, 24'h000000);
    cfg_pins <= p;
    repeat (3) @(posedge clk);
    dw(R_PINS, {8'h00, p});
  endtask
  function automatic logic [2:0] dma_exp(input logic [2:0] c,
    input logic [1:0] hm);
    if (c == DM_HOST) begin
      return {1'h1, hm};
    end
    return c;
  endfunction
  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    logic [23:0] w;
    logic [23:0] v;
    logic [7:0] q;
    logic [1:0] f;
    logic [15:0] d;
    logic [15:0] r;
    logic [2:0] c;
    logic [15:0] pv [5];
    void'($urandom(41922));
    pv = '{16'h0058, 16'h0258, 16'h085E, 16'h1058, 16'hB658};
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    dr(R_STAT, v);
    `CHK("status", 24'h000002, v)
    dr(R_BASE, v);
    `CHK("base", 24'h000080, v)
    dr(R_GPDIR, v);
    `CHK("pin dir", 24'h000000, v)
    `CHK("pin oe", 16'hFFFF, gp_oe_b)
    dw(R_STAT, 24'hFFFFFF);
    dr(R_STAT, v);
    `CHK("status ro", 24'h000002, v)
    for (int i = 0; i < 5; i++) begin
      pins(pv[i]);
      hc(H_HCTL, {2'h0, i[0], 5'h00}, 1'h1, q);
      w = (i == 0) ? 24'hFFFFFF : 24'($urandom);
      hw24(w, i[0]);
      dr(R_STAT, v);
      `CHK("rx full", 1'h1, v[0])
      dr(R_RXW, v);
      `CHK("rx word", w, v)
      dr(R_STAT, v);
      `CHK("rx empty", 1'h0, v[0])
      w = (i == 1) ? 24'h000000 : 24'($urandom);
      dw(R_TXW, w);
      dr(R_STAT, v);
      `CHK("tx full", 1'h0, v[1])
      hr24(i[0], v);
      `CHK("tx word", w, v)
      dr(R_STAT, v);
      `CHK("tx empty", 1'h1, v[1])
    end
    pins(16'h0058);
    hc(H_HCTL, 8'h00, 1'h1, q);
    dw(R_CTRL, 24'h000007);
    repeat (2) @(posedge clk);
    `CHK("irq tx", {1'h1, VEC_TX}, {irq_req, irq_vec})
    hw24(24'h123456, 1'h0);
    `CHK("irq rx", VEC_RX, irq_vec)
    hc(H_CMD, 8'h80, 1'h1, q);
    `CHK("irq cmd", VEC_CMD, irq_vec)
    dr(R_STAT, v);
    `CHK("cmd pending", 1'h1, v[2])
    irq_ack <= 1'h1;
    @(posedge clk);
    irq_ack <= 1'h0;
    repeat (2) @(posedge clk);
    `CHK("irq acked", VEC_RX, irq_vec)
    dr(R_STAT, v);
    `CHK("cmd cleared", 1'h0, v[2])
    dr(R_RXW, v);
    repeat (2) @(posedge clk);
    `CHK("irq last", VEC_TX, irq_vec)
    dw(R_CTRL, 24'h000000);
    repeat (2) @(posedge clk);
    `CHK("irq off", 1'h0, irq_req)
    f = 2'($urandom);
    hc(H_HCTL, {3'h0, f, 3'h0}, 1'h1, q);
    dr(R_STAT, v);
    `CHK("host flags", f, v[4:3])
    dw(R_CTRL, {19'h0, ~f, 3'h0});
    hc(H_ISR, 8'h00, 1'h0, q);
    `CHK("dsp flags", ~f, q[4:3])
    hc(H_HCTL, 8'h01, 1'h1, q);
    for (int i = 0; i < 12; i++) begin
      c = (i < 8) ? i[2:0] : DM_HOST;
      if (i > 7) hc(H_HCTL, {1'h0, i[1:0], 5'h01}, 1'h1, q);
      dw(R_CTRL, {16'h0, c, 5'h00});
      repeat (2) @(posedge clk);
      `CHK("dma", dma_exp(c, i[1:0]), {dma_to_host, dma_width})
      dr(R_STAT, v);
      `CHK("dma status", c != DM_OFF, v[7])
    end
    dw(R_CTRL, 24'h000000);
    hc(H_HCTL, 8'h02, 1'h1, q);
    repeat (2) @(posedge clk);
    `CHK("req on", 1'h1, req_seen)
    hc(H_HCTL, 8'h00, 1'h1, q);
    repeat (2) @(posedge clk);
    `CHK("req off", 1'h0, req_seen)
    // A waiting transmit word drives only the receive-side request pin.
    dw(R_TXW, 24'h00A5C3);
    hc(H_HCTL, 8'h05, 1'h1, q);
    repeat (2) @(posedge clk);
    `CHK("ack split", 1'h1, ack_seen)
    `CHK("req split", 1'h0, req_seen)
    pins(16'h0158);
    for (int i = 0; i < 2; i++) begin
      hc(H_HCTL, {6'h00, i[0], 1'h0}, 1'h1, q);
      repeat (2) @(posedge clk);
      `CHK("od drive", 1'h0, link.req_out & ~link.req_oe_b)
      `CHK("od req", i[0], req_seen)
    end
    pins(16'h0001);
    d = 16'($urandom);
    r = 16'($urandom);
    gp_in <= 16'($urandom);
    dw(R_GPD, {8'h00, d});
    dw(R_GPDIR, {8'h00, r});
    repeat (2) @(posedge clk);
    `CHK("pin out", d, gp_out)
    `CHK("pin oe", ~r, gp_oe_b)
    dr(R_GPDIR, v);
    `CHK("pin dir back", {8'h00, r}, v)
    dr(R_GPD, v);
    `CHK("pin in", {8'h00, (r & d) | (~r & gp_in)}, v)
    pins(16'h0000);
    repeat (2) @(posedge clk);
    `CHK("pins off", 16'hFFFF, gp_oe_b)
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule
